/* hw/fasr_pkg.sv */
// package: opcodes, field positions, reset values and timing for the status readout link
package fasr_pkg;
  // opcodes
  localparam logic [7:0] OPC_READ_SUSPEND = 8'h09;
  localparam logic [7:0] OPC_READ_CONFIG = 8'h95;
  localparam logic [7:0] OPC_READ_PROTECT = 8'h85;
  localparam logic [7:0] OPC_QUAD_ENTER = 8'h38;
  localparam logic [7:0] OPC_QUAD_EXIT = 8'hFF;
  // suspend status fields
  localparam int SUS_BUSY_BIT = 0;
  localparam int SUS_ERASE_BIT = 2;
  localparam int SUS_PROG_BIT = 3;
  // config status fields
  localparam int CFG_DUMMY_LSB = 4;
  localparam int CFG_DRIVE_LSB = 2;
  localparam logic [1:0] CFG_DUMMY_RESET = 2'h0;
  localparam logic [1:0] CFG_DRIVE_RESET = 2'h0;
  // link timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_PERIOD_NS = 160;
  localparam int SCLK_HALF_CYCLES = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  // host register map (byte addresses)
  localparam logic [7:0] HREG_CTRL = 8'h00;
  localparam logic [7:0] HREG_STATUS = 8'h04;
  localparam logic [7:0] HREG_DATA = 8'h08;
  // device receive phase
  typedef enum logic [1:0] {
    PH_OPCODE = 2'b00,
    PH_DATA = 2'b01,
    PH_IGNORE = 2'b10
  } fasr_phase_t;
  // host sequencer state
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_RUN = 2'b01,
    HS_GAP = 2'b10
  } fasr_hstate_t;
endpackage : fasr_pkg

/* hw/fasr_if.sv */
// interface: serial link between host controller and flash status readout
`timescale 1ns/1ps
`default_nettype none
interface fasr_if;
  logic sclk;
  logic cs_n;
  logic [3:0] host_dq_o;
  logic [3:0] host_dq_oe;
  logic [3:0] dev_dq_o;
  logic [3:0] dev_dq_oe;
  logic [3:0] dq;
  // wire level per line: device, then host, else pull-up
  genvar i;
  for (i = 0; i < 4; i++) begin : g_line
    assign dq[i] = dev_dq_oe[i] ? dev_dq_o[i] : (host_dq_oe[i] ? host_dq_o[i] : 1'b1);
  end
  modport dev (input sclk, input cs_n, input dq, output dev_dq_o, output dev_dq_oe);
  modport host (output sclk, output cs_n, input dq, output host_dq_o, output host_dq_oe);
endinterface : fasr_if
`default_nettype wire

/* hw/fasr_device.sv */
// flash end: auxiliary status registers and their serial read commands
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module fasr_device
  import fasr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // serial link
  fasr_if.dev link,
  // core status
  input wire logic write_busy_flag,
  input wire logic erase_active,
  input wire logic program_active,
  input wire logic suspend_req,
  input wire logic resume_req,
  input wire logic soft_reset,
  input wire logic [7:0] protect_status,
  // config register write from the status-write logic
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_wdata,
  // state shown to the core
  output logic four_wire_command_mode,
  output logic [7:0] suspend_status,
  output logic [7:0] read_timing_drive_config,
  output logic [2:0] dummy_bytes,
  output logic [3:0] dummy_clocks,
  output logic [1:0] drive_strength
);

  typedef struct packed {
    logic [2:0] sclk_sync;
    logic [1:0] cs_sync;
    logic [3:0] dq_s1;
    logic [3:0] dq_s2;
    fasr_phase_t phase;
    logic [2:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] opcode;
    logic [7:0] txsh;
    logic quad;
    logic enter_pend;
    logic exit_pend;
    logic erase_paused;
    logic program_paused;
    logic [1:0] dummy_sel;
    logic [1:0] drive_sel;
    logic [3:0] dq_o;
    logic [3:0] dq_oe;
  } fasr_dev_state_t;

  fasr_dev_state_t s;
  fasr_dev_state_t next_s;

  // dummy length in bytes for a config setting
  function automatic logic [2:0] fasr_dummy_len(input logic [1:0] sel);
    unique case (sel)
      2'h0: fasr_dummy_len = 3'h3;
      2'h1: fasr_dummy_len = 3'h2;
      2'h2: fasr_dummy_len = 3'h4;
      2'h3: fasr_dummy_len = 3'h5;
    endcase
  endfunction : fasr_dummy_len

  // live value of the register an opcode selects
  function automatic logic [7:0] fasr_select(input logic [7:0] opc, input logic [7:0] sus,
                                             input logic [7:0] cfg, input logic [7:0] prot);
    if (opc == OPC_READ_SUSPEND) begin
      fasr_select = sus;
    end else if (opc == OPC_READ_CONFIG) begin
      fasr_select = cfg;
    end else begin
      fasr_select = prot;
    end
  endfunction : fasr_select

  logic rise;
  logic fall;
  logic selected;
  logic [2:0] step;
  logic [7:0] opc_in;
  logic [7:0] out_byte;

  // register views built from state and the write_busy_flag input
  always_comb begin
    suspend_status = 8'h00;
    suspend_status[SUS_BUSY_BIT] = write_busy_flag;
    suspend_status[SUS_ERASE_BIT] = s.erase_paused;
    suspend_status[SUS_PROG_BIT] = s.program_paused;
    read_timing_drive_config = 8'h00;
    read_timing_drive_config[CFG_DUMMY_LSB +: 2] = s.dummy_sel;
    read_timing_drive_config[CFG_DRIVE_LSB +: 2] = s.drive_sel;
  end

  // core-facing decodes
  assign four_wire_command_mode = s.quad;
  assign dummy_bytes = fasr_dummy_len(s.dummy_sel);
  assign dummy_clocks = {fasr_dummy_len(s.dummy_sel), 1'b0};
  assign drive_strength = s.drive_sel;
  assign link.dev_dq_o = s.dq_o;
  assign link.dev_dq_oe = s.dq_oe;

  // link edges seen after the synchronisers
  assign rise = s.sclk_sync[1] & ~s.sclk_sync[2];
  assign fall = ~s.sclk_sync[1] & s.sclk_sync[2];
  assign selected = ~s.cs_sync[1];
  assign step = s.quad ? 3'h4 : 3'h1;
  assign opc_in = s.quad ? {s.shreg[3:0], s.dq_s2} : {s.shreg[6:0], s.dq_s2[0]};
  assign out_byte = (s.bitcnt == 3'h0) ?
                    fasr_select(s.opcode, suspend_status, read_timing_drive_config,
                                protect_status) : s.txsh;

  // next state of the whole device end
  always_comb begin
    next_s = s;
    next_s.sclk_sync = {s.sclk_sync[1:0], link.sclk};
    next_s.cs_sync = {s.cs_sync[0], link.cs_n};
    next_s.dq_s1 = link.dq;
    next_s.dq_s2 = s.dq_s1;
    // suspend flags: a new suspend beats a resume in the same cycle
    if (resume_req) begin
      next_s.erase_paused = 1'b0;
      next_s.program_paused = 1'b0;
    end
    if (suspend_req && erase_active) begin
      next_s.erase_paused = 1'b1;
    end
    if (suspend_req && program_active) begin
      next_s.program_paused = 1'b1;
    end
    if (soft_reset) begin
      next_s.erase_paused = 1'b0;
      next_s.program_paused = 1'b0;
    end
    if (cfg_wr) begin
      next_s.dummy_sel = cfg_wdata[CFG_DUMMY_LSB +: 2];
      next_s.drive_sel = cfg_wdata[CFG_DRIVE_LSB +: 2];
    end
    if (!selected) begin
      // frame over: release lines, apply mode change
      next_s.phase = PH_OPCODE;
      next_s.bitcnt = 3'h0;
      next_s.dq_oe = 4'h0;
      next_s.enter_pend = 1'b0;
      next_s.exit_pend = 1'b0;
      if (s.enter_pend) begin
        next_s.quad = 1'b1;
      end
      if (s.exit_pend) begin
        next_s.quad = 1'b0;
      end
    end else if (rise && s.phase == PH_OPCODE) begin
      // opcode enters on rising edges
      next_s.shreg = opc_in;
      next_s.bitcnt = s.bitcnt + step;
      if (3'(s.bitcnt + step) == 3'h0) begin
        next_s.opcode = opc_in;
        next_s.phase = PH_IGNORE;
        if (opc_in == OPC_READ_SUSPEND || opc_in == OPC_READ_CONFIG ||
            opc_in == OPC_READ_PROTECT) begin
          next_s.phase = PH_DATA;
        end else if (opc_in == OPC_QUAD_ENTER && !s.quad) begin
          next_s.enter_pend = 1'b1;
        end else if (opc_in == OPC_QUAD_EXIT && s.quad) begin
          next_s.exit_pend = 1'b1;
        end
      end
    end else if (fall && s.phase == PH_DATA) begin
      // status byte leaves MSB first on falling edges, endlessly
      next_s.bitcnt = s.bitcnt + step;
      if (s.quad) begin
        next_s.dq_o = out_byte[7:4];
        next_s.dq_oe = 4'hF;
        next_s.txsh = {out_byte[3:0], 4'h0};
      end else begin
        next_s.dq_o = {2'b00, out_byte[7], 1'b0};
        next_s.dq_oe = 4'h2;
        next_s.txsh = {out_byte[6:0], 1'b0};
      end
    end
  end

  // state register; reset clears every bit except the select and data synchronisers, which start high
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.sclk_sync <= 3'h0;
      s.cs_sync <= 2'h3;
      s.dq_s1 <= 4'hF;
      s.dq_s2 <= 4'hF;
      s.phase <= PH_OPCODE;
      s.dummy_sel <= CFG_DUMMY_RESET;
      s.drive_sel <= CFG_DRIVE_RESET;
    end else begin
      s <= next_s;
    end
  end

endmodule : fasr_device
`default_nettype wire

/* hw/fasr_host.sv */
// host end: serial controller that sends one opcode and reads status bytes
`timescale 1ns/1ps
`default_nettype none
module fasr_host
  import fasr_pkg::*;
#(
  parameter int HALF_CYCLES = SCLK_HALF_CYCLES
)
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // serial link
  fasr_if.host link
);

  typedef struct packed {
    fasr_hstate_t state;
    logic [7:0] div;
    logic sclk;
    logic cs_n;
    logic [11:0] beat;
    logic [11:0] total;
    logic [11:0] opb;
    logic [7:0] opc;
    logic [7:0] txsh;
    logic quad;
    logic [2:0] rxbits;
    logic [7:0] rxsh;
    logic [7:0] rx_data;
    logic [7:0] rx_count;
    logic [3:0] dq_o;
    logic [3:0] dq_oe;
    logic [3:0] s1;
    logic [3:0] s2;
    logic [31:0] rdata;
  } fasr_host_state_t;

  fasr_host_state_t s;
  fasr_host_state_t next_s;

  logic tick;
  logic [7:0] rx_in;
  logic [2:0] step;

  assign tick = (s.div == 8'(HALF_CYCLES - 1));
  assign step = s.quad ? 3'h4 : 3'h1;
  assign rx_in = s.quad ? {s.rxsh[3:0], s.s2} : {s.rxsh[6:0], s.s2[1]};
  assign rdata = s.rdata;
  assign link.sclk = s.sclk;
  assign link.cs_n = s.cs_n;
  assign link.host_dq_o = s.dq_o;
  assign link.host_dq_oe = s.dq_oe;

  // next state of the controller
  always_comb begin
    next_s = s;
    next_s.s1 = link.dq;
    next_s.s2 = s.s1;
    next_s.rdata = 32'h0;
    // register reads answer in the following cycle only
    if (rd) begin
      if (addr == HREG_STATUS) begin
        next_s.rdata = {16'h0, s.rx_count, 6'h0, s.quad, s.state != HS_IDLE};
      end else if (addr == HREG_DATA) begin
        next_s.rdata = {24'h0, s.rx_data};
      end
    end
    unique case (s.state)
      HS_IDLE: begin
        if (wr && addr == HREG_CTRL) begin
          // start a frame: opcode out first, data bytes after
          next_s.state = HS_RUN;
          next_s.div = 8'h0;
          next_s.sclk = 1'b0;
          next_s.cs_n = 1'b0;
          next_s.beat = 12'h0;
          next_s.opc = wdata[7:0];
          next_s.opb = s.quad ? 12'h2 : 12'h8;
          next_s.total = (s.quad ? 12'h2 : 12'h8) *
                         (12'h1 + {4'h0, wdata[15:8]});
          next_s.rx_count = 8'h0;
          next_s.rxbits = 3'h0;
          if (s.quad) begin
            next_s.dq_o = wdata[7:4];
            next_s.dq_oe = 4'hF;
            next_s.txsh = {wdata[3:0], 4'h0};
          end else begin
            next_s.dq_o = {3'b000, wdata[7]};
            next_s.dq_oe = 4'h1;
            next_s.txsh = {wdata[6:0], 1'b0};
          end
        end
      end
      HS_RUN: begin
        next_s.div = tick ? 8'h0 : 8'(s.div + 8'h1);
        if (tick) begin
          next_s.sclk = ~s.sclk;
          if (!s.sclk) begin
            // rising edge: count beat, sample data after the opcode
            next_s.beat = s.beat + 12'h1;
            if (s.beat >= s.opb) begin
              next_s.rxsh = rx_in;
              next_s.rxbits = s.rxbits + step;
              if (3'(s.rxbits + step) == 3'h0) begin
                next_s.rx_data = rx_in;
                next_s.rx_count = s.rx_count + 8'h1;
              end
            end
          end else if (s.beat == s.total) begin
            // falling edge after the last beat closes the frame
            next_s.cs_n = 1'b1;
            next_s.dq_oe = 4'h0;
            next_s.state = HS_GAP;
            if (s.opc == OPC_QUAD_ENTER && !s.quad) begin
              next_s.quad = 1'b1;
            end else if (s.opc == OPC_QUAD_EXIT && s.quad) begin
              next_s.quad = 1'b0;
            end
          end else if (s.beat < s.opb) begin
            // falling edge: next opcode bits
            if (s.quad) begin
              next_s.dq_o = s.txsh[7:4];
              next_s.txsh = {s.txsh[3:0], 4'h0};
            end else begin
              next_s.dq_o = {3'b000, s.txsh[7]};
              next_s.txsh = {s.txsh[6:0], 1'b0};
            end
          end else begin
            next_s.dq_oe = 4'h0;
          end
        end
      end
      HS_GAP: begin
        // keep select high for a full period before the next frame
        next_s.div = 8'(s.div + 8'h1);
        if (s.div == 8'(2 * HALF_CYCLES - 1)) begin
          next_s.div = 8'h0;
          next_s.state = HS_IDLE;
        end
      end
      default: begin
        next_s.state = HS_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.state <= HS_IDLE;
      s.cs_n <= 1'b1;
      s.s1 <= 4'hF;
      s.s2 <= 4'hF;
    end else begin
      s <= next_s;
    end
  end

endmodule : fasr_host
`default_nettype wire

/* sim/fasr_props.sv */
// checker: wire timing and drive relations between host and device ends
`timescale 1ns/1ps
`default_nettype none
module fasr_props (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // link signals
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] host_dq_o,
  input wire logic [3:0] host_dq_oe,
  input wire logic [3:0] dev_dq_o,
  input wire logic [3:0] dev_dq_oe
);
  logic [3:0] fall_age;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // cycles since the last serial clock fall, saturating
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fall_age <= 4'hF;
    end else if ($fell(sclk)) begin
      fall_age <= 4'h0;
    end else if (fall_age != 4'hF) begin
      fall_age <= fall_age + 4'h1;
    end
  end
  AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
    else $error("serial clock high while deselected");
  AST_FIRST_RISE: assert property ($fell(cs_n) |-> ##[1:24] $rose(sclk))
    else $error("no serial clock rise after select");
  AST_HOST_HOLD: assert property ($rose(sclk) && !cs_n |-> $stable(host_dq_o & host_dq_oe))
    else $error("host line moved at a rising edge");
  AST_NO_FIGHT: assert property ((dev_dq_oe & host_dq_oe) == 4'h0)
    else $error("both ends drive one line");
  AST_DEV_LINES: assert property (dev_dq_oe inside {4'h0, 4'h2, 4'hF})
    else $error("device drives an odd set of lines");
  AST_DEV_RELEASE: assert property ($rose(cs_n) |-> ##[0:5] (dev_dq_oe == 4'h0))
    else $error("device keeps driving after deselect");
  AST_DEV_TIMING: assert property ($changed(dev_dq_o) && !cs_n && (dev_dq_oe != 4'h0)
    |-> fall_age <= 4'h6)
    else $error("device output changed away from a falling edge");
  AST_DEV_HOLD: assert property ($rose(sclk) && (dev_dq_oe != 4'h0)
    |-> $stable(dev_dq_o) ##1 $stable(dev_dq_o))
    else $error("device output moved around a rising edge");
endmodule : fasr_props
`default_nettype wire

/* sim/flash_aux_status_readout_tb_top.sv */
// testbench: host and device joined, driven through the host register port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %0h got %0h", nm, e, s); end end
module flash_aux_status_readout_tb_top
  import fasr_pkg::*;
;
  logic clk, resetn, wr, rd;
  logic [7:0] addr, prot, cfg_wdata, b, c, sus_st, cfg_st, op_sh;
  logic [31:0] wdata, rdata, st;
  logic core_busy, erase_on, prog_on, sus_req, res_req, srst, cfg_wr, quad_mode;
  logic [2:0] dmy_b;
  logic [3:0] dmy_c;
  logic [1:0] drv, d, s;
  logic [15:0] dat_sh;
  logic [2:0] dtab [4] = '{3'h3, 3'h2, 3'h4, 3'h5};
  int error_cnt, checks, rise_n, i;
  fasr_if lnk ();
  fasr_host fasr_host_inst (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .link(lnk));
  fasr_device fasr_device_inst (.clk(clk), .resetn(resetn), .link(lnk),
    .write_busy_flag(core_busy), .erase_active(erase_on), .program_active(prog_on),
    .suspend_req(sus_req), .resume_req(res_req), .soft_reset(srst), .protect_status(prot),
    .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .four_wire_command_mode(quad_mode),
    .suspend_status(sus_st), .read_timing_drive_config(cfg_st), .dummy_bytes(dmy_b),
    .dummy_clocks(dmy_c), .drive_strength(drv));
  fasr_props fasr_props_inst (.clk(clk), .resetn(resetn), .sclk(lnk.sclk), .cs_n(lnk.cs_n),
    .host_dq_o(lnk.host_dq_o), .host_dq_oe(lnk.host_dq_oe), .dev_dq_o(lnk.dev_dq_o),
    .dev_dq_oe(lnk.dev_dq_oe));
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // wire monitor: opcode on line 0, then data on line 1, at rising edges
  always @(negedge lnk.cs_n) rise_n = 0;
  always @(posedge lnk.sclk) begin
    if (rise_n < 8) op_sh = {op_sh[6:0], lnk.dq[0]};
    else dat_sh = {dat_sh[14:0], lnk.dq[1]};
    rise_n++;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg
  // one-cycle pulse on a core event input: 0 suspend, 1 resume, else soft reset
  task automatic pulse(input int w);
    @(posedge clk);
    if (w == 0) sus_req <= 1'b1;
    else if (w == 1) res_req <= 1'b1;
    else srst <= 1'b1;
    @(posedge clk);
    sus_req <= 1'b0;
    res_req <= 1'b0;
    srst <= 1'b0;
    #1;
  endtask : pulse
  task automatic go(input logic [7:0] op, input logic [7:0] n);
    wr_reg(HREG_CTRL, {16'h0000, n, op});
  endtask : go
  // poll busy with a bound, then fetch count and last byte
  task automatic fin(output logic [7:0] lb, output logic [7:0] cnt);
    logic [31:0] v;
    int k;
    v = 32'h1;
    k = 0;
    while (v[0] !== 1'b0 && k < 2000) begin
      rd_reg(HREG_STATUS, v);
      k++;
    end
    `CHK("busy clear", 1'b0, v[0])
    cnt = v[15:8];
    rd_reg(HREG_DATA, v);
    lb = v[7:0];
  endtask : fin
  task automatic rdf(input logic [7:0] op, input logic [7:0] n, input logic [7:0] e);
    logic [7:0] lb, cnt;
    go(op, n);
    fin(lb, cnt);
    if (n != 8'h00) `CHK("link byte", e, lb)
    `CHK("byte count", n, cnt)
  endtask : rdf
  task print_verdict;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict
  // watchdog
  initial begin
    #600000;
    error_cnt++;
    $display("watchdog expired");
    print_verdict();
  end
  // main sequence
  initial begin
    {resetn, wr, rd, core_busy, erase_on, prog_on, sus_req, res_req, srst, cfg_wr} = '0;
    addr = 8'h00;
    wdata = 32'h0;
    prot = 8'hA5;
    cfg_wdata = 8'h00;
    error_cnt = 0;
    checks = 0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("suspend reset", 8'h00, sus_st)
    `CHK("dummy reset", 3'h3, dmy_b)
    `CHK("drive reset", 2'h0, drv)
    rdf(OPC_READ_SUSPEND, 8'h01, 8'h00);
    rd_reg(8'h0C, st);
    `CHK("unmapped read", 32'h0, st)
    $display("test reset done");
    @(posedge clk);
    core_busy <= 1'b1;
    erase_on <= 1'b1;
    pulse(0);
    `CHK("erase paused", 8'h05, sus_st)
    go(OPC_READ_SUSPEND, 8'h02);
    repeat (180) @(posedge clk);
    pulse(1);
    fin(b, c);
    `CHK("polled second", 8'h01, b)
    `CHK("polled first", 8'h05, dat_sh[15:8])
    `CHK("masked poll", 8'h01, b & 8'h0D)
    `CHK("opcode bits", OPC_READ_SUSPEND, op_sh)
    @(posedge clk);
    erase_on <= 1'b0;
    prog_on <= 1'b1;
    pulse(0);
    `CHK("program paused", 8'h09, sus_st)
    @(posedge clk);
    core_busy <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("busy mirror", 8'h08, sus_st)
    pulse(1);
    `CHK("program resumed", 8'h00, sus_st)
    pulse(0);
    pulse(2);
    `CHK("soft reset", 8'h00, sus_st)
    $display("test suspend done");
    for (i = 0; i < 4; i++) begin
      d = 2'(i);
      s = 2'(3 - i);
      @(posedge clk);
      cfg_wr <= 1'b1;
      cfg_wdata <= {2'b11, d, s, 2'b11};
      @(posedge clk);
      cfg_wr <= 1'b0;
      #1;
      `CHK("config", {2'b00, d, s, 2'b00}, cfg_st)
      `CHK("dummy bytes", dtab[i], dmy_b)
      `CHK("dummy clocks", {dtab[i], 1'b0}, dmy_c)
      `CHK("drive", s, drv)
      rdf(OPC_READ_CONFIG, 8'h01, {2'b00, d, s, 2'b00});
    end
    $display("test config done");
    @(posedge clk);
    core_busy <= 1'b1;
    rdf(OPC_READ_PROTECT, 8'h03, 8'hA5);
    `CHK("protect wire", 16'hA5A5, dat_sh)
    $display("test protect done");
    rdf(OPC_QUAD_ENTER, 8'h00, 8'h00);
    `CHK("quad mode", 1'b1, quad_mode)
    rd_reg(HREG_STATUS, st);
    `CHK("host quad", 1'b1, st[1])
    pulse(0);
    rdf(OPC_READ_SUSPEND, 8'h02, 8'h09);
    rdf(OPC_READ_CONFIG, 8'h01, 8'h30);
    rdf(OPC_READ_PROTECT, 8'h02, 8'hA5);
    rdf(OPC_QUAD_EXIT, 8'h00, 8'h00);
    `CHK("single mode", 1'b0, quad_mode)
    rdf(OPC_READ_CONFIG, 8'h01, 8'h30);
    rdf(8'h5A, 8'h01, 8'hFF);
    `CHK("still single", 1'b0, quad_mode)
    $display("test quad done");
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("suspend after reset", 8'h01, sus_st)
    `CHK("config after reset", 8'h00, cfg_st)
    rdf(OPC_READ_SUSPEND, 8'h01, 8'h01);
    $display("test second reset done");
    print_verdict();
  end
endmodule : flash_aux_status_readout_tb_top
`default_nettype wire
